// File: core/ssdb_defines.svh
`ifndef SSDB_DEFINES_SVH
`define SSDB_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define SSDB_IDX_CTRL1     12'h000
`define SSDB_IDX_CTRL2     12'h001
`define SSDB_IDX_FLAGS     12'h003
`define SSDB_IDX_UPPER     12'h004
`define SSDB_IDX_LOWER     12'h005
`define SSDB_IDX_PAIR      12'h006
`define SSDB_ADDR_CTRL1    12'h000
`define SSDB_ADDR_CTRL2    12'h004
`define SSDB_ADDR_FLAGS    12'h00c
`define SSDB_ADDR_UPPER    12'h010
`define SSDB_ADDR_LOWER    12'h014
`define SSDB_ADDR_PAIR     12'h018

// Field positions.
`define SSDB_BIT_RX_FULL   7
`define SSDB_BIT_TX_EMPTY  5
`define SSDB_BIT_FAULT     4
`define SSDB_BIT_IRQ_EN    7
`define SSDB_BIT_MASTER    4
`define SSDB_BIT_FAULT_EN  4
`define SSDB_BIT_WIDE      6

// Reset values.
`define SSDB_RST_DATA      8'h00
`define SSDB_RST_CTRL      8'h00

`endif

// File: core/ssdb_pkg.sv
package ssdb_pkg;
   typedef logic [7:0]  ssdb_byte_t;
   typedef logic [15:0] ssdb_word_t;
   typedef logic [31:0] ssdb_data_t;
   typedef enum logic [1:0]
   {
      SSDB_RESP_OKAY   = 2'b00,
      SSDB_RESP_DECERR = 2'b11
   } ssdb_resp_t;
endpackage

// File: core/ssdb_flag_seq.sv
`timescale 1ns/100ps
// Arms on a status read that sees the flag set and fires on the following access.
module ssdb_flag_seq
(
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Sequence events.
   input  wire logic flag,
   input  wire logic status_read,
   input  wire logic access_evt,
   // Result.
   output logic      clear_pulse
);
   logic armed_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         armed_reg <= 1'b0;
      else if (status_read && flag)
         armed_reg <= 1'b1;
      else if (access_evt || !flag)
         armed_reg <= 1'b0;
   end

   assign clear_pulse = armed_reg && access_evt && flag;
endmodule

// File: core/ssdb_top.sv
`timescale 1ns/100ps
`include "ssdb_defines.svh"
// What this block does
// - Status register readable anytime; writes to it change nothing.
// - Receive-full flag at bit 7 sets when a word enters the data register.
// - In 8-bit width, status read with flag set then low read clears it.
// - In 16-bit width, low-byte or word read after armed status read clears flag.
// - Low-only read in 16-bit width keeps the received upper byte readable in the data register.
// - Transmit-empty flag at bit 5 shows whether transmit register is empty.
// - Transmit-empty clears only on low write after status read saw it set.
// - Data writes while transmit-empty is zero are ignored.
// - Mode-fault bit 4 sets on select low as master with detection enabled.
// - Mode fault clears on status read seeing it, then first write to control register 1.
// - Data pair returns received data, takes transmit data, resets to zero.
// - As master, a queued word starts once the previous transfer finishes.
// - Word finished with receive-full clear moves to data register, sets flag.
// - Second word while flag set is held in shift register, data unchanged.
// - Servicing before third transfer moves held word in, flag stays set.
// - Servicing after third transfer starts drops the held word.
// - Mode fault with interrupt enable set requests an interrupt.
// - Transfer width follows the wide select bit of second control register.
module ssdb_top
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset.
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Write address channel.
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // Write data channel.
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // Write response channel.
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // Read address channel.
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // Read data channel.
   output ssdb_pkg::ssdb_data_t       s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Shift engine side.
   input  wire logic                  rx_done,
   input  wire ssdb_pkg::ssdb_word_t  rx_word,
   input  wire logic                  xfer_start,
   input  wire logic                  shifter_idle,
   output ssdb_pkg::ssdb_word_t       tx_word,
   output logic                       tx_load,
   output logic                       wide_mode,
   output logic                       master_mode,
   output logic                       fault_abort,
   // Slave select pin.
   input  wire logic                  select_n_pin,
   // Interrupt request.
   output logic                       port_irq
);
   import ssdb_pkg::*;

   logic        aw_held_reg;
   logic        w_held_reg;
   logic [11:0] aw_addr_reg;
   ssdb_data_t  w_data_reg;
   logic        w_lane0_reg;
   logic        w_lane1_reg;
   logic        bvalid_reg;
   ssdb_resp_t  bresp_reg;
   logic        rvalid_reg;
   ssdb_data_t  rdata_reg;
   ssdb_resp_t  rresp_reg;
   logic        wr_fire;
   logic        rd_fire;
   logic [11:0] rd_addr;
   ssdb_data_t  rd_mux;
   logic        rd_hit;
   logic        wr_hit;

   ssdb_byte_t  ctrl1_reg;
   ssdb_byte_t  ctrl2_reg;
   logic        receive_full_flag;
   logic        transmit_empty_flag;
   logic        mode_fault_flag;
   ssdb_word_t  rx_data_reg;
   ssdb_word_t  held_word_reg;
   logic        held_valid_reg;
   ssdb_byte_t  tx_upper_reg;
   ssdb_word_t  tx_word_reg;
   logic        tx_load_reg;
   logic        select_meta_reg;
   logic        select_sync_reg;
   logic        fault_detect;

   logic        status_read;
   logic        low_read;
   logic        low_write;
   logic        upper_write;
   logic        ctrl1_write;
   logic        rx_clear;
   logic        tx_clear;
   logic        fault_clear;
   ssdb_byte_t  flags_value;

   // AXI4-Lite handshakes.
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign rd_addr       = 12'(s_axi_araddr);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= 12'(s_axi_awaddr);
      end
      else if (wr_fire)
         aw_held_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_lane0_reg <= 1'b0;
         w_lane1_reg <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_reg  <= 1'b1;
         w_data_reg  <= s_axi_wdata;
         w_lane0_reg <= s_axi_wstrb[0];
         w_lane1_reg <= s_axi_wstrb[1];
      end
      else if (wr_fire)
         w_held_reg <= 1'b0;
   end

   // Write decode.
   always_comb
   begin
      if (aw_addr_reg == `SSDB_ADDR_CTRL1 || aw_addr_reg == `SSDB_ADDR_CTRL2)
         wr_hit = 1'b1;
      else if (aw_addr_reg == `SSDB_ADDR_FLAGS || aw_addr_reg == `SSDB_ADDR_UPPER)
         wr_hit = 1'b1;
      else if (aw_addr_reg == `SSDB_ADDR_LOWER || aw_addr_reg == `SSDB_ADDR_PAIR)
         wr_hit = 1'b1;
      else
         wr_hit = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= SSDB_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit ? SSDB_RESP_OKAY : SSDB_RESP_DECERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // Access events seen by the flag sequences and the transmit path.
   assign ctrl1_write = wr_fire && w_lane0_reg && aw_addr_reg == `SSDB_ADDR_CTRL1;
   assign upper_write = wr_fire && ((w_lane0_reg && aw_addr_reg == `SSDB_ADDR_UPPER)
                        || (w_lane1_reg && aw_addr_reg == `SSDB_ADDR_PAIR));
   assign low_write   = wr_fire && w_lane0_reg
                        && (aw_addr_reg == `SSDB_ADDR_LOWER || aw_addr_reg == `SSDB_ADDR_PAIR);
   assign status_read = rd_fire && rd_addr == `SSDB_ADDR_FLAGS;
   assign low_read    = rd_fire && (rd_addr == `SSDB_ADDR_LOWER || rd_addr == `SSDB_ADDR_PAIR);

   // Status bits and reserved zeros.
   always_comb
   begin
      flags_value = 8'h00;
      flags_value[`SSDB_BIT_RX_FULL]  = receive_full_flag;
      flags_value[`SSDB_BIT_TX_EMPTY] = transmit_empty_flag;
      flags_value[`SSDB_BIT_FAULT]    = mode_fault_flag;
   end

   // Read decode.
   always_comb
   begin
      rd_hit = 1'b1;
      if (rd_addr == `SSDB_ADDR_CTRL1)
         rd_mux = {24'h000000, ctrl1_reg};
      else if (rd_addr == `SSDB_ADDR_CTRL2)
         rd_mux = {24'h000000, ctrl2_reg};
      else if (rd_addr == `SSDB_ADDR_FLAGS)
         rd_mux = {24'h000000, flags_value};
      else if (rd_addr == `SSDB_ADDR_UPPER)
         rd_mux = {24'h000000, rx_data_reg[15:8]};
      else if (rd_addr == `SSDB_ADDR_LOWER)
         rd_mux = {24'h000000, rx_data_reg[7:0]};
      else if (rd_addr == `SSDB_ADDR_PAIR)
         rd_mux = {16'h0000, rx_data_reg};
      else
      begin
         rd_mux = 32'h0000_0000;
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= SSDB_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= rd_hit ? SSDB_RESP_OKAY : SSDB_RESP_DECERR;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // Control registers; a mode fault drops master mode.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl1_reg <= `SSDB_RST_CTRL;
      else
      begin
         if (ctrl1_write)
            ctrl1_reg <= w_data_reg[7:0];
         if (fault_detect)
            ctrl1_reg[`SSDB_BIT_MASTER] <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl2_reg <= `SSDB_RST_CTRL;
      else if (wr_fire && w_lane0_reg && aw_addr_reg == `SSDB_ADDR_CTRL2)
         ctrl2_reg <= w_data_reg[7:0];
   end

   assign wide_mode   = ctrl2_reg[`SSDB_BIT_WIDE];
   assign master_mode = ctrl1_reg[`SSDB_BIT_MASTER];

   // Clearing sequences.
   // receive clear sequence
   ssdb_flag_seq u_rx_seq
   (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .flag        (receive_full_flag),
      .status_read (status_read),
      .access_evt  (low_read),
      .clear_pulse (rx_clear)
   );

   ssdb_flag_seq u_tx_seq
   (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .flag        (transmit_empty_flag),
      .status_read (status_read),
      .access_evt  (low_write),
      .clear_pulse (tx_clear)
   );

   ssdb_flag_seq u_fault_seq
   (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .flag        (mode_fault_flag),
      .status_read (status_read),
      .access_evt  (ctrl1_write),
      .clear_pulse (fault_clear)
   );

   // Receive path with one held word.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         receive_full_flag <= 1'b0;
         rx_data_reg       <= {`SSDB_RST_DATA, `SSDB_RST_DATA};
         held_valid_reg    <= 1'b0;
         held_word_reg     <= 16'h0000;
      end
      else if (rx_clear)
      begin
         if (held_valid_reg)
         begin
            rx_data_reg    <= held_word_reg;
            held_valid_reg <= 1'b0;
         end
         else if (rx_done)
            rx_data_reg <= wide_mode ? rx_word : {8'h00, rx_word[7:0]};
         receive_full_flag <= held_valid_reg || rx_done;
      end
      else if (rx_done && !receive_full_flag)
      begin
         rx_data_reg       <= wide_mode ? rx_word : {8'h00, rx_word[7:0]};
         receive_full_flag <= 1'b1;
      end
      else if (rx_done)
      begin
         held_word_reg  <= wide_mode ? rx_word : {8'h00, rx_word[7:0]};
         held_valid_reg <= 1'b1;
      end
      else if (xfer_start && held_valid_reg)
         held_valid_reg <= 1'b0;
   end

   // Transmit path.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         transmit_empty_flag <= 1'b1;
         tx_upper_reg        <= `SSDB_RST_DATA;
         tx_word_reg         <= {`SSDB_RST_DATA, `SSDB_RST_DATA};
      end
      else
      begin
         if (upper_write && transmit_empty_flag)
            tx_upper_reg <= (aw_addr_reg == `SSDB_ADDR_PAIR) ? w_data_reg[15:8] : w_data_reg[7:0];
         if (tx_clear)
         begin
            tx_word_reg         <= {wide_mode ? (upper_write ? w_data_reg[15:8] : tx_upper_reg) : 8'h00,
                                    w_data_reg[7:0]};
            transmit_empty_flag <= 1'b0;
         end
         else if (tx_load_reg)
            transmit_empty_flag <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_load_reg <= 1'b0;
      else
         tx_load_reg <= master_mode && !transmit_empty_flag && shifter_idle && !tx_load_reg && !fault_detect;
   end

   assign tx_load = tx_load_reg;
   assign tx_word = tx_word_reg;

   // Slave select synchroniser.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         select_meta_reg <= 1'b1;
         select_sync_reg <= 1'b1;
      end
      else
      begin
         select_meta_reg <= select_n_pin;
         select_sync_reg <= select_meta_reg;
      end
   end

   assign fault_detect = !select_sync_reg && master_mode && ctrl2_reg[`SSDB_BIT_FAULT_EN];
   assign fault_abort  = fault_detect;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_fault_flag <= 1'b0;
      else if (fault_detect)
         mode_fault_flag <= 1'b1;
      else if (fault_clear)
         mode_fault_flag <= 1'b0;
   end

   assign port_irq = mode_fault_flag && ctrl1_reg[`SSDB_BIT_IRQ_EN];
endmodule

// File: test/ssdb_props.sv
`timescale 1ns/100ps
module ssdb_props
(
   // Clock and reset.
   input wire logic                 aclk,
   input wire logic                 aresetn,
   // Bus handshakes.
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire ssdb_pkg::ssdb_data_t s_axi_rdata,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   // Engine and pins.
   input wire logic                 tx_load,
   input wire logic                 shifter_idle,
   input wire logic                 master_mode,
   input wire logic                 fault_abort,
   input wire logic                 select_n_pin,
   input wire logic                 port_irq
);
   import ssdb_pkg::*;
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read not answered one cycle after address.");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("Read address taken while data pending.");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data not held.");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:4] s_axi_bvalid)
      else $error("Write response late.");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response not held.");
   load_pulse_a: assert property (tx_load |=> !tx_load)
      else $error("Load longer than one cycle.");
   load_idle_a: assert property (tx_load |-> $past(shifter_idle) && $past(master_mode))
      else $error("Load while engine busy or not master.");
   fault_cause_a: assert property ($rose(fault_abort) |-> !$past(select_n_pin, 2))
      else $error("Fault without select low.");
   fault_slave_a: assert property (fault_abort |=> !master_mode)
      else $error("Master kept after fault.");
   irq_fault_a: assert property ($rose(port_irq) |-> ##[0:1] !master_mode)
      else $error("Interrupt without fault.");
endmodule

bind ssdb_top ssdb_props props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .tx_load, .shifter_idle, .master_mode, .fault_abort, .select_n_pin, .port_irq);

// File: test/ssdb_peer.sv
`timescale 1ns/100ps
module ssdb_peer
(
   // Clock.
   input wire logic                 aclk,
   // Transmit side.
   input wire ssdb_pkg::ssdb_word_t tx_word,
   input wire logic                 tx_load,
   // Receive side.
   output logic                     rx_done,
   output ssdb_pkg::ssdb_word_t     rx_word,
   output logic                     xfer_start,
   output logic                     shifter_idle,
   // Observation.
   output ssdb_pkg::ssdb_word_t     last_word,
   output int                       loads
);
   import ssdb_pkg::*;
   int         lat = 40;
   int         busy = 0;
   logic       t_done = 1'b0;
   logic       s_done = 1'b0;
   logic       s_start = 1'b0;
   ssdb_word_t s_word = 16'h5a5a;
   initial loads = 0;
   initial last_word = 16'h0000;
   assign shifter_idle = (busy == 0);
   assign rx_done = t_done | s_done;
   assign rx_word = t_done ? ~last_word : s_word;
   assign xfer_start = s_start | tx_load;
   always @(posedge aclk)
   begin
      t_done <= (busy == 1);
      if (tx_load === 1'b1)
      begin
         last_word <= tx_word;
         loads <= loads + 1;
         busy <= lat;
      end
      else if (busy > 0)
         busy <= busy - 1;
   end
   // Runs a transfer started by the far master; d low stops after the start.
   task automatic recv(input ssdb_word_t w, input logic d);
      @(posedge aclk);
      s_start <= 1'b1;
      @(posedge aclk);
      s_start <= 1'b0;
      repeat (4) @(posedge aclk);
      s_word <= w;
      s_done <= d;
      @(posedge aclk);
      s_done <= 1'b0;
      s_word <= ~w;
   endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
`include "ssdb_defines.svh"
module tb_top;
   import ssdb_pkg::*;
   localparam logic [11:0] A_FL = `SSDB_ADDR_FLAGS;
   localparam logic [11:0] A_UP = `SSDB_ADDR_UPPER;
   localparam logic [11:0] A_LO = `SSDB_ADDR_LOWER;
   localparam logic [11:0] A_PR = `SSDB_ADDR_PAIR;
   localparam logic [11:0] A_C1 = `SSDB_ADDR_CTRL1;
   localparam logic [11:0] A_C2 = `SSDB_ADDR_CTRL2;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_done, xfer_start;
   logic        shifter_idle, tx_load, wide_mode, master_mode, fault_abort, select_n_pin, port_irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   ssdb_data_t  s_axi_rdata, d;
   ssdb_word_t  rx_word, tx_word, last_word;
   int          loads, fail_count, checks_done;

   ssdb_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_done, .rx_word, .xfer_start,
      .shifter_idle, .tx_word, .tx_load, .wide_mode, .master_mode, .fault_abort, .select_n_pin, .port_irq);
   ssdb_peer peer (.aclk, .tx_word, .tx_load, .rx_done, .rx_word, .xfer_start, .shifter_idle, .last_word, .loads);

   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk_reg(input ssdb_data_t e, input ssdb_data_t g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic chk_sig(input ssdb_word_t e, input ssdb_word_t g);
      chk_reg({16'h0000, e}, {16'h0000, g});
   endtask

   task automatic axi_wr(input logic [11:0] a, input ssdb_data_t v, input logic [3:0] s);
      logic ta, tw, done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (100)
         if (!done)
         begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            done = (s_axi_bvalid === 1'b1);
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
         end
      if (!done)
      begin
         chk_reg(32'h1, 32'h0);
         finish_test;
      end
   endtask

   task automatic axi_rd(input logic [11:0] a, output ssdb_data_t v, output logic [1:0] rs);
      logic ta, done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (100)
         if (!done)
         begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            done = (s_axi_rvalid === 1'b1);
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
         end
      if (!done)
      begin
         chk_reg(32'h1, 32'h0);
         finish_test;
      end
   endtask

   task automatic rchk(input logic [11:0] a, input ssdb_data_t e, input ssdb_data_t m = 32'hffffffff);
      ssdb_data_t v;
      logic [1:0] rs;
      axi_rd(a, v, rs);
      chk_reg(e, v & m);
   endtask

   task automatic wait_loads(input int n);
      repeat (200) if (loads < n) @(posedge aclk);
      if (loads < n)
      begin
         chk_reg(32'h1, 32'h0);
         finish_test;
      end
   endtask

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
      {select_n_pin, fail_count, checks_done} = 65'h1_0000_0000_0000_0000;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(A_FL, 32'h20);
      rchk(A_UP, 32'h00);
      rchk(A_LO, 32'h00);
      axi_wr(A_FL, 32'hff, 4'hf);
      chk_reg(32'h0, {30'h0, r});
      rchk(A_FL, 32'h20);
      axi_rd(12'h100, d, r);
      chk_reg(32'h3, {30'h0, r});
      axi_wr(12'h100, 32'h0, 4'h1);
      chk_reg(32'h3, {30'h0, r});
      $display("Reset and register test finished.");
      peer.recv(16'h77a5, 1'b1);
      rchk(A_LO, 32'ha5);
      rchk(A_FL, 32'ha0);
      rchk(A_LO, 32'ha5);
      rchk(A_FL, 32'h20);
      $display("Narrow receive test finished.");
      axi_wr(A_C2, 32'h40, 4'h1);
      chk_sig(16'h1, {15'h0, wide_mode});
      peer.recv(16'h1234, 1'b1);
      peer.recv(16'h5678, 1'b1);
      rchk(A_FL, 32'ha0);
      rchk(A_UP, 32'h12);
      rchk(A_FL, 32'ha0);
      rchk(A_LO, 32'h34);
      rchk(A_FL, 32'ha0);
      rchk(A_PR, 32'h5678);
      rchk(A_FL, 32'h20);
      peer.recv(16'h1a2b, 1'b1);
      peer.recv(16'h3c4d, 1'b1);
      peer.recv(16'h0000, 1'b0);
      rchk(A_FL, 32'ha0);
      rchk(A_LO, 32'h2b);
      rchk(A_FL, 32'h20);
      $display("Overrun test finished.");
      axi_wr(A_C1, 32'h10, 4'h1);
      axi_wr(A_UP, 32'hc3, 4'h1);
      axi_wr(A_UP, 32'hc3, 4'h1);
      rchk(A_FL, 32'h20);
      chk_sig(16'h0, loads[15:0]);
      axi_wr(A_LO, 32'h5e, 4'h1);
      wait_loads(1);
      chk_sig(16'hc35e, last_word);
      rchk(A_FL, 32'h20);
      axi_wr(A_PR, 32'h0f0f, 4'h3);
      rchk(A_FL, 32'h00);
      axi_wr(A_PR, 32'h1111, 4'h3);
      wait_loads(2);
      chk_sig(16'h0f0f, last_word);
      axi_wr(A_LO, 32'h99, 4'h1);
      rchk(A_FL, 32'ha0);
      chk_sig(16'h2, loads[15:0]);
      $display("Transmit test finished.");
      axi_wr(A_C2, 32'h50, 4'h1);
      axi_wr(A_C1, 32'h90, 4'h1);
      select_n_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      select_n_pin <= 1'b1;
      axi_wr(A_C1, 32'h80, 4'h1);
      rchk(A_FL, 32'h30, 32'h30);
      chk_sig(16'h1, {15'h0, port_irq});
      chk_sig(16'h0, {15'h0, master_mode});
      axi_wr(A_C1, 32'h80, 4'h1);
      rchk(A_FL, 32'h20, 32'h30);
      chk_sig(16'h0, {15'h0, port_irq});
      $display("Mode fault test finished.");
      finish_test;
   end
endmodule
